//--- design/clock_startup_reset_sequencer.sv
// Clock start-up reset sequencer: time-out, oscillator start-up, range decode, divide by eight
//
// How it works
// - Time-out starts after other resets release.
// - Time-out counted in watchdog oscillator cycles.
// - Time-out lengths 0, 4096 or 8192 cycles.
// - Ripple count of oscillator cycles, then release.
// - Start-up counts from 6 up to 32K.
// - Reset exit uses time-out plus start-up count.
// - Sleep wake uses start-up count only.
// - Upper select bits pick frequency-range mode.
// - Reset exit adds 14 oscillator cycles.
// - Group 0, codes 00/01: 258 cycles.
// - Group 0, code 10: 1K, no time-out.
// - 1K with 4096 or 8192 cycle time-out.
// - Group 1, code 01: 16K, no time-out.
// - Group 1, codes 10/11: 16K with time-out.
// - Programmed divide fuse divides clock by eight.
// - Fuse reads 1 unprogrammed, 0 programmed.
// - Select 1111..1000 chooses low power crystal.
`timescale 1ns/1ps
module clock_startup_reset_sequencer
    import startup_seq_pkg::*;
#(
    parameter int TOUT_SHORT = TOUT_SHORT_CYC,
    parameter int TOUT_LONG  = TOUT_LONG_CYC,
    parameter int START_16K  = START_16K_CYC,
    parameter int START_32K  = START_32K_CYC
)(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Oscillator pins
    input  wire logic        wdt_osc_pin,
    input  wire logic        sel_osc_pin,
    // Reset sources and sleep control
    input  wire logic        other_resets_released,
    input  wire logic        sleep_enter,
    input  wire logic        sleep_wake,
    // Outputs to the core
    output logic             internal_reset_n,
    output logic             sysclk_en,
    output osc_range_t       osc_range
);

    // Time-out length chosen by the fuses, in watchdog cycles
    function automatic logic [15:0] tout_cycles(input fuse_t f);
        logic [15:0] r;
        r = 16'(TOUT_NONE_CYC);
        if (f.clock_source_select_fuses[3:1] == 3'b011 || f.clock_source_select_fuses[3])
        begin
            case ({f.clock_source_select_fuses[0], f.startup_time_fuses})
                3'b000, 3'b011, 3'b110: r = 16'(TOUT_SHORT);
                3'b001, 3'b100, 3'b111: r = 16'(TOUT_LONG);
                default:                r = 16'(TOUT_NONE_CYC);
            endcase
        end
        else
        begin
            case (f.startup_time_fuses)
                2'b01:   r = 16'(TOUT_SHORT);
                2'b10:   r = 16'(TOUT_LONG);
                default: r = 16'(TOUT_NONE_CYC);
            endcase
        end
        return r;
    endfunction : tout_cycles

    // Oscillator start-up length chosen by the fuses
    function automatic logic [15:0] start_cycles(input fuse_t f);
        logic [15:0] r;
        r = START_EXT_CYC;
        if (f.clock_source_select_fuses[3] || f.clock_source_select_fuses[3:1] == 3'b011)
        begin
            case ({f.clock_source_select_fuses[0], f.startup_time_fuses})
                3'b000, 3'b001:         r = START_258_CYC;
                3'b010, 3'b011, 3'b100: r = START_1K_CYC;
                default:                r = 16'(START_16K);
            endcase
        end
        else if (f.clock_source_select_fuses[3:1] == 3'b010)
            r = f.clock_source_select_fuses[0] ? 16'(START_32K) : START_1K_CYC;
        return r;
    endfunction : start_cycles

    fuse_t       fuse_r;
    fuse_t       cfg_r;
    seq_state_t  state_r;
    seq_state_t  state_nxt;
    logic        from_reset_r;
    logic [15:0] tout_tgt_r;
    logic [15:0] start_tgt_r;
    logic [2:0]  div_cnt_r;
    logic        sysclk_en_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic        rel_meta_r;
    logic        rel_sync_r;
    logic        wdt_step;
    logic        osc_step;
    logic [15:0] tout_cnt;
    logic [15:0] start_cnt;
    logic        tout_done;
    logic        start_done;
    logic        lp_sel;
    logic        div8_prog;
    logic        running;

    // Oscillator edges become one-cycle enables
    pin_edge_sync u_wdt_sync (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pin_in     (wdt_osc_pin),
        .rise_pulse (wdt_step)
    );

    pin_edge_sync u_osc_sync (
        .clk_sys    (clk_sys),
        .rst_n      (rst_n),
        .pin_in     (sel_osc_pin),
        .rise_pulse (osc_step)
    );

    // Watchdog time-out counter, cleared outside its state
    step_counter u_tout_cnt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (state_r != S_TOUT),
        .step    (wdt_step),
        .target  (tout_tgt_r),
        .count   (tout_cnt),
        .done    (tout_done)
    );

    // Oscillator ripple counter, idle until the time-out is over
    step_counter u_start_cnt (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .clear   (state_r != S_START),
        .step    (osc_step),
        .target  (start_tgt_r),
        .count   (start_cnt),
        .done    (start_done)
    );

    // Synchronise the release of the other reset sources
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rel_meta_r <= 1'b0;
            rel_sync_r <= 1'b0;
        end
        else
        begin
            rel_meta_r <= other_resets_released;
            rel_sync_r <= rel_meta_r;
        end
    end

    // Fuse decode, fuse 0 means programmed
    assign lp_sel    = fuse_r.clock_source_select_fuses[3];
    assign div8_prog = ~cfg_r.divide_by_eight_fuse;
    assign osc_range = osc_range_t'(fuse_r.clock_source_select_fuses[2:1]);
    assign running   = (state_r == S_RUN);

    // Sequencer next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_HOLD:  if (rel_sync_r) state_nxt = S_TOUT;
            S_TOUT:  if (tout_done)  state_nxt = S_START;
            S_START: if (start_done) state_nxt = S_RUN;
            S_RUN:   if (sleep_enter) state_nxt = S_SLEEP;
            S_SLEEP: if (sleep_wake) state_nxt = S_START;
            default: state_nxt = S_HOLD;
        endcase
        if (!rel_sync_r)
            state_nxt = S_HOLD;
    end

    // State and snapshot of the fuse setting for each sequence
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r      <= S_HOLD;
            cfg_r        <= fuse_t'(FUSE_RST);
            from_reset_r <= 1'b1;
            tout_tgt_r   <= 16'h0000;
            start_tgt_r  <= 16'h0000;
        end
        else
        begin
            state_r <= state_nxt;
            if (state_r == S_HOLD)
            begin
                cfg_r        <= fuse_r;
                from_reset_r <= 1'b1;
                tout_tgt_r   <= tout_cycles(fuse_r);
                start_tgt_r  <= 16'(start_cycles(fuse_r) + EXTRA_RST_CYC);
            end
            else if (state_r == S_SLEEP && sleep_wake)
            begin
                cfg_r        <= fuse_r;
                from_reset_r <= 1'b0;
                start_tgt_r  <= start_cycles(fuse_r);
            end
        end
    end

    // System clock enable, optionally every eighth oscillator edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_cnt_r   <= 3'h0;
            sysclk_en_r <= 1'b0;
        end
        else
        begin
            if (!running)
                div_cnt_r <= 3'h0;
            else if (osc_step)
                div_cnt_r <= 3'(div_cnt_r + 3'h1);
            sysclk_en_r <= running && osc_step && (!div8_prog || div_cnt_r == DIV8_LAST);
        end
    end

    assign sysclk_en        = sysclk_en_r;
    assign internal_reset_n = (state_r == S_RUN) || (state_r == S_SLEEP);

    // Wishbone decode
    wire       wb_req   = wb_cyc_i && wb_stb_i;
    wire       wb_wr    = wb_req && wb_we_i && ack_r && wb_sel_i[0];
    wire       hit_fuse = (wb_adr_i == FUSE_OFS);
    wire [31:0] status_word = 32'(
        ({31'h0, !internal_reset_n} << ST_RESET_POS) |
        ({29'h0, state_r} << ST_STATE_POS) |
        ({30'h0, osc_range} << ST_RANGE_POS) |
        ({31'h0, lp_sel} << ST_LPSEL_POS));
    wire [31:0] rd_mux = hit_fuse                     ? {25'h0, fuse_r} :
                         (wb_adr_i == STATUS_OFS)     ? status_word :
                         (wb_adr_i == COUNT_OFS)      ? {tout_cnt, start_cnt} : 32'h0;

    // One wait state; write lands on the ack edge
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_r  <= 1'b0;
            dat_r  <= 32'h0;
            fuse_r <= fuse_t'(FUSE_RST);
        end
        else
        begin
            ack_r <= wb_req && !ack_r;
            if (wb_req && !ack_r)
                dat_r <= rd_mux;
            if (wb_wr && hit_fuse)
                fuse_r <= fuse_t'(wb_dat_i[6:0]);
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;

    // Checks
    AST_HOLD_WHILE_OTHERS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !rel_sync_r |=> !internal_reset_n) else $error("reset released while others active");
    AST_TOUT_FULL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_TOUT && state_nxt == S_START) |-> tout_cnt >= tout_tgt_r)
        else $error("time-out left early");
    AST_TOUT_LEN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_TOUT |-> (tout_tgt_r == 16'(TOUT_SHORT) || tout_tgt_r == 16'(TOUT_LONG) || tout_tgt_r == 16'h0))
        else $error("illegal time-out length");
    AST_START_FULL: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(state_r == S_RUN) |-> $past(start_cnt) >= $past(start_tgt_r))
        else $error("start-up count cut short");
    AST_START_AFTER_TOUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_TOUT |-> start_cnt == 16'h0 && !internal_reset_n)
        else $error("start-up counted during time-out");
    AST_WAKE_SKIPS_TOUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_SLEEP && sleep_wake && rel_sync_r) |=> state_r == S_START && !from_reset_r)
        else $error("wake did not go to start-up");
    AST_EXTRA_AFTER_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_r == S_START && from_reset_r) |-> start_tgt_r == 16'(start_cycles(cfg_r) + EXTRA_RST_CYC))
        else $error("reset start-up lacks extra cycles");
    AST_RANGE_MAP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        lp_sel |-> osc_range == (fuse_r.clock_source_select_fuses[2:1] == 2'h0 ? RANGE_0M4_0M9 :
                                 fuse_r.clock_source_select_fuses[2:1] == 2'h1 ? RANGE_0M9_3M0 :
                                 fuse_r.clock_source_select_fuses[2:1] == 2'h2 ? RANGE_3M0_8M0 :
                                 RANGE_8M0_16M))
        else $error("range mode decode wrong");
    AST_DIV8: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sysclk_en && div8_prog) |-> $past(div_cnt_r) == DIV8_LAST)
        else $error("divided clock enable off phase");
    AST_WB_ACK_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

    COV_RESET_EXIT: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_START ##1 state_r == S_RUN);
    COV_WAKE: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_SLEEP ##1 state_r == S_START);
    COV_DIV8_RUN: cover property (@(posedge clk_sys) disable iff (!rst_n)
        sysclk_en && div8_prog);
    COV_ZERO_TOUT: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == S_TOUT && tout_tgt_r == 16'h0);

endmodule : clock_startup_reset_sequencer

//--- design/pin_edge_sync.sv
// Two-flop synchroniser with rising-edge pulse for an oscillator pin
`timescale 1ns/1ps
module pin_edge_sync
    import startup_seq_pkg::*;
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // Pin in, pulse out
    input  wire logic pin_in,
    output logic      rise_pulse
);

    logic meta_r;
    logic sync_r;
    logic prev_r;

    // Only sync_r reads meta_r
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            prev_r <= 1'b0;
        end
        else
        begin
            meta_r <= pin_in;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    // One pulse per oscillator rising edge
    assign rise_pulse = sync_r & ~prev_r;

    AST_PULSE_SINGLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rise_pulse |=> !rise_pulse) else $error("edge pulse lasted two cycles");

endmodule : pin_edge_sync

//--- design/startup_seq_pkg.sv
// Constants, types and register map of the clock start-up reset sequencer
package startup_seq_pkg;

    // Register byte offsets on the Wishbone slave
    localparam logic [3:0] FUSE_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] COUNT_OFS  = 4'h8;

    // Fuse word: 1 = unprogrammed, 0 = programmed
    typedef struct packed {
        logic       divide_by_eight_fuse;
        logic [1:0] startup_time_fuses;
        logic [3:0] clock_source_select_fuses;
    } fuse_t;

    // Fuse value after reset: internal RC, long time-out, divide by eight
    localparam logic [6:0] FUSE_RST = 7'h22;

    // Watchdog time-out lengths in watchdog oscillator cycles
    localparam int TOUT_NONE_CYC  = 0;
    localparam int TOUT_SHORT_CYC = 4096;
    localparam int TOUT_LONG_CYC  = 8192;

    // Oscillator start-up lengths in oscillator cycles
    localparam logic [15:0] START_EXT_CYC  = 16'h0006;
    localparam logic [15:0] START_258_CYC  = 16'h0102;
    localparam logic [15:0] START_1K_CYC   = 16'h0400;
    localparam int          START_16K_CYC  = 16384;
    localparam int          START_32K_CYC  = 32768;
    localparam logic [15:0] EXTRA_RST_CYC  = 16'h000E;

    // Divide-by-eight prescaler terminal count
    localparam logic [2:0]  DIV8_LAST      = 3'h7;

    // Status register field positions
    localparam int ST_RESET_POS = 0;
    localparam int ST_STATE_POS = 1;
    localparam int ST_RANGE_POS = 4;
    localparam int ST_LPSEL_POS = 6;

    // Sequencer states
    typedef enum logic [2:0] {
        S_HOLD  = 3'b000,
        S_TOUT  = 3'b001,
        S_START = 3'b010,
        S_RUN   = 3'b011,
        S_SLEEP = 3'b100
    } seq_state_t;

    // Low power crystal frequency-range modes
    typedef enum logic [1:0] {
        RANGE_0M4_0M9 = 2'b00,
        RANGE_0M9_3M0 = 2'b01,
        RANGE_3M0_8M0 = 2'b10,
        RANGE_8M0_16M = 2'b11
    } osc_range_t;

    // Wishbone classic request carrier
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

endpackage : startup_seq_pkg

//--- design/step_counter.sv
// Counter of enable pulses with a target and a done flag
`timescale 1ns/1ps
module step_counter
    import startup_seq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    // Control
    input  wire logic        clear,
    input  wire logic        step,
    input  wire logic [15:0] target,
    // Status
    output logic [15:0]      count,
    output logic             done
);

    logic [15:0] count_r;
    logic [15:0] count_nxt;

    // Clear wins, count stops at the target
    assign count_nxt = clear ? 16'h0000 :
                       (step && !done) ? 16'(count_r + 16'h0001) : count_r;

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            count_r <= 16'h0000;
        else
            count_r <= count_nxt;
    end

    assign count = count_r;
    assign done  = (count_r >= target);

    AST_CNT_NO_OVERRUN: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (!clear && done) |=> (count_r == $past(count_r))) else $error("counter ran past target");

endmodule : step_counter

//--- verification/clock_startup_reset_sequencer_tb.sv
// Self-checking testbench of the clock start-up reset sequencer
`timescale 1ns/1ps
module clock_startup_reset_sequencer_tb;
    import startup_seq_pkg::*;

    // Shortened time-out and long start-up counts
    localparam int T_S  = 8;
    localparam int T_L  = 16;
    localparam int S16  = 32;
    localparam int S32  = 64;
    localparam int XR   = int'(EXTRA_RST_CYC);
    localparam int C258 = int'(START_258_CYC);
    localparam int C1K  = int'(START_1K_CYC);
    localparam int C6   = int'(START_EXT_CYC);

    // Design stimulus and response
    logic        clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [3:0]  wb_sel_i, wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic        wb_ack_o, wdt_osc_pin, sel_osc_pin, other_resets_released;
    logic        sleep_enter, sleep_wake, internal_reset_n, sysclk_en;
    osc_range_t  osc_range;
    int          err_count, comparisons, en_count;
    logic [6:0]  fz [10];
    int          tz [10];
    int          sz [10];

    clock_startup_reset_sequencer #(
        .TOUT_SHORT (T_S),
        .TOUT_LONG  (T_L),
        .START_16K  (S16),
        .START_32K  (S32)
    ) u_dut (
        .clk_sys               (clk_sys),
        .rst_n                 (rst_n),
        .wb_cyc_i              (wb_cyc_i),
        .wb_stb_i              (wb_stb_i),
        .wb_we_i               (wb_we_i),
        .wb_sel_i              (wb_sel_i),
        .wb_adr_i              (wb_adr_i),
        .wb_dat_i              (wb_dat_i),
        .wb_dat_o              (wb_dat_o),
        .wb_ack_o              (wb_ack_o),
        .wdt_osc_pin           (wdt_osc_pin),
        .sel_osc_pin           (sel_osc_pin),
        .other_resets_released (other_resets_released),
        .sleep_enter           (sleep_enter),
        .sleep_wake            (sleep_wake),
        .internal_reset_n      (internal_reset_n),
        .sysclk_en             (sysclk_en),
        .osc_range             (osc_range)
    );

    // 40 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Counts system clock enable pulses
    always @(posedge clk_sys)
    begin
        if (sysclk_en === 1'b1)
            en_count <= en_count + 1;
    end

    // Compares one value and reports a difference
    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
            err_count++;
        end
    endtask : check

    // Prints the verdict and ends the run
    task test_done;
        if (err_count == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done

    // One classic Wishbone cycle, waits for ack with no bound of its own
    task wb(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hF;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        // Request stands until ack; only the watchdog ends a hung wait
        do
        begin
            @(posedge clk_sys);
        end
        while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    // Lets synchronisers and the sequencer catch up
    task settle;
        repeat (8) @(posedge clk_sys);
    endtask : settle

    // Gives n rising edges on the watchdog (0) or selected (1) oscillator pin
    task edges(input int which, input int n);
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_sys);
            if (which == 0) wdt_osc_pin <= 1'b1;
            else sel_osc_pin <= 1'b1;
            repeat (3) @(posedge clk_sys);
            if (which == 0) wdt_osc_pin <= 1'b0;
            else sel_osc_pin <= 1'b0;
            repeat (2) @(posedge clk_sys);
        end
    endtask : edges

    // Reads the sequencer state from the status register
    task state_is(input seq_state_t exp, input string what);
        wb(1'b0, STATUS_OFS, 32'h0, rd);
        check({29'h0, rd[3:1]}, {29'h0, exp}, what);
    endtask : state_is

    // Full sequence from a release of the other reset sources
    task run_seq(input logic [6:0] fuse, input int tout, input int start);
        int e0;
        @(posedge clk_sys);
        other_resets_released <= 1'b0;
        wb(1'b1, FUSE_OFS, {25'h0, fuse}, rd);
        settle;
        edges(0, 2);
        state_is(S_HOLD, "held while others assert");
        @(posedge clk_sys);
        other_resets_released <= 1'b1;
        settle;
        if (tout > 0)
        begin
            state_is(S_TOUT, "time-out entered");
            edges(1, 3);
            edges(0, tout - 1);
            settle;
            state_is(S_TOUT, "time-out one short");
            wb(1'b0, COUNT_OFS, 32'h0, rd);
            check({16'h0, rd[31:16]}, 32'(tout - 1), "time-out count");
            check({16'h0, rd[15:0]}, 32'h0, "start-up idle in time-out");
            edges(0, 1);
            settle;
        end
        state_is(S_START, "start-up after time-out");
        edges(1, start - 1);
        settle;
        check({31'h0, internal_reset_n}, 32'h0, "reset one edge short");
        edges(1, 1);
        settle;
        check({31'h0, internal_reset_n}, 32'h1, "reset released");
        e0 = en_count;
        edges(1, 16);
        settle;
        check(en_count - e0, fuse[6] ? 32'h10 : 32'h2, "clock enables per 16 edges");
    endtask : run_seq

    // Reset values, unmapped access, range decode
    task regs_and_range;
        logic [3:0] s;
        wb(1'b0, FUSE_OFS, 32'h0, rd);
        check(rd, 32'h22, "fuse reset value");
        check({30'h0, osc_range}, 32'h1, "range at reset");
        wb(1'b1, 4'hC, 32'h7F, rd);
        wb(1'b0, 4'hC, 32'h0, rd);
        check(rd, 32'h0, "unmapped read");
        wb(1'b0, FUSE_OFS, 32'h0, rd);
        check(rd, 32'h22, "fuse after unmapped write");
        for (int k = 0; k < 8; k++)
        begin
            s = 4'h8 + 4'(k);
            wb(1'b1, FUSE_OFS, {25'h0, 3'h4, s}, rd); // upper bits 100: divide fuse unprogrammed, start-up fuses 00
            settle;
            check({30'h0, osc_range}, {30'h0, s[2:1]}, "range mode");
            wb(1'b0, STATUS_OFS, 32'h0, rd);
            check({31'h0, rd[6]}, 32'h1, "low power crystal chosen");
        end
        wb(1'b1, FUSE_OFS, 32'h42, rd);
        settle;
        wb(1'b0, STATUS_OFS, 32'h0, rd);
        check({31'h0, rd[6]}, 32'h0, "internal RC not low power");
    endtask : regs_and_range

    // Sleep entry, refused wake in run, wake without time-out
    task sleep_wake_seq;
        @(posedge clk_sys);
        sleep_wake <= 1'b1;
        @(posedge clk_sys);
        sleep_wake <= 1'b0;
        settle;
        state_is(S_RUN, "wake ignored in run");
        @(posedge clk_sys);
        sleep_enter <= 1'b1;
        @(posedge clk_sys);
        sleep_enter <= 1'b0;
        settle;
        state_is(S_SLEEP, "sleep entered");
        @(posedge clk_sys);
        sleep_wake <= 1'b1;
        @(posedge clk_sys);
        sleep_wake <= 1'b0;
        settle;
        state_is(S_START, "wake skips time-out");
        edges(1, S32 - 1);
        settle;
        check({31'h0, internal_reset_n}, 32'h0, "wake one edge short");
        edges(1, 1);
        settle;
        check({31'h0, internal_reset_n}, 32'h1, "wake released without extra");
    endtask : sleep_wake_seq

    // Bounds the run length
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        $display("mismatch at %0t: watchdog expired", $time);
        err_count++;
        test_done;
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_sel_i = 4'h0;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h0;
        wdt_osc_pin = 1'b0;
        sel_osc_pin = 1'b0;
        other_resets_released = 1'b0;
        sleep_enter = 1'b0;
        sleep_wake = 1'b0;
        err_count = 0;
        comparisons = 0;
        fz = '{7'h5F, 7'h6F, 7'h3F, 7'h4E, 7'h5E, 7'h6E, 7'h7E, 7'h4F, 7'h40, 7'h45};
        tz = '{0, T_S, T_L, T_S, T_L, 0, T_S, T_L, 0, 0};
        sz = '{S16 + XR, S16 + XR, S16 + XR, C258 + XR, C258 + XR, C1K + XR, C1K + XR, C1K + XR,
               C6 + XR, S32 + XR};
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        regs_and_range;
        for (int i = 0; i < 10; i++)
            run_seq(fz[i], tz[i], sz[i]);
        sleep_wake_seq;
        test_done;
    end

endmodule : clock_startup_reset_sequencer_tb
